// *** hw/pmc_defines.vh ***
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// Register indices (printed offsets); byte address is index * 4
`define PMC_IDX_PHY_STATUS 5'h10
`define PMC_IDX_INT_CTRL 5'h11
`define PMC_IDX_INT_STATUS 5'h12
`define PMC_IDX_PCS_CFG 5'h16
`define PMC_IDX_LED_CTRL 5'h18
`define PMC_IDX_PHY_CTRL 5'h19
`define PMC_IDX_TEN_BASE 5'h1a
`define PMC_IDX_ENERGY_CTRL 5'h1d
// Own register: power down request and strap readback
`define PMC_IDX_MODE_CTRL 5'h1e

// Interrupt control fields
`define PMC_IC_TEST 2
`define PMC_IC_IRQ_EN 1
`define PMC_IC_OUT_EN 0
`define PMC_IC_MASK 16'h0007

// Interrupt status fields: flags 14:8, unmask 6:0
`define PMC_IS_FLAG_LO 8
`define PMC_IS_FLAG_HI 14
`define PMC_IS_UNMASK_MASK 16'h007f

// PCS, LED, PHY control, 10BT fields
`define PMC_PCS_BYPASS 12
`define PMC_PCS_MASK 16'h1000
`define PMC_LED_SPD_DRV 5
`define PMC_LED_ACT_DRV 3
`define PMC_LED_SPD_VAL 2
`define PMC_LED_ACT_VAL 0
`define PMC_LED_MASK 16'h002d
`define PMC_PHYC_MASK 16'h0040
`define PMC_TEN_SERIAL 15
`define PMC_TEN_MASK 16'hf000
`define PMC_PHY_STATUS_IRQ 7

// Energy detect control fields
`define PMC_ED_ENABLE 15
`define PMC_ED_MASK 16'h8000

// Own mode register fields
`define PMC_MC_PDOWN 0
`define PMC_MC_PIN_IRQ 1

// Default station address from weak pulls
`define PMC_ADDR_DEFAULT 5'h01

// Timing
`define PMC_CLK_MHZ 200
`define PMC_REF_MII_MHZ 25
`define PMC_REF_RMII_MHZ 50

// Bus responses
`define PMC_RESP_OKAY 2'b00
`define PMC_RESP_SLVERR 2'b10

`endif

// *** hw/pmc_clk_div.v ***
`timescale 1ns/1ps
`include "pmc_defines.vh"

module pmc_clk_div #(
    parameter HALF_W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [HALF_W-1:0] half_period,
    output reg clk_out
);
    reg [HALF_W-1:0] cnt_q;

    // Toggle every half period of source cycles
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= {HALF_W{1'b0}};
            clk_out <= 1'b0;
        end else if (cnt_q >= half_period - 1'b1) begin
            cnt_q <= {HALF_W{1'b0}};
            clk_out <= ~clk_out;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// *** hw/pmc_top.v ***
`timescale 1ns/1ps
`include "pmc_defines.vh"

// Notes on behaviour
// - Reduced mode clocks from 50 MHz oscillator
// - Data-valid strap high selects reduced mode
// - Crossover on unless error strap low
// - Crossover picks pair after negotiation
// - Energy detect idles low power, monitors line
// - Line activity restores normal power
// - Energy detect controlled at register 1Dh
// - Reference out 25 or 50 MHz
// - Shared pin open-drain low on interrupt
// - Without interrupt pin, register power down
// - Serial mode uses bit 0 only
// - Interrupt control bits 2,1,0 at 11h
// - Status flags 14:8, unmask 6:0 at 12h
// - PCS bit 12 bypasses block code
// - LED override drive and value bits
// - Unsupported vendor bits read reserved zero
// - Address strapped from data and collision

module pmc_top #(
    parameter HAS_IRQ_PIN = 1,
    parameter HALF_W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire rx_dv_strap,
    input wire rx_er_strap,
    input wire [3:0] rxd_strap,
    input wire col_strap,
    input wire serial_network_mode_strap,
    input wire [6:0] event_in,
    input wire line_activity,
    input wire negotiation_crossed,
    input wire negotiation_done,
    input wire speed_led_status,
    input wire activity_led_status,
    input wire powerdown_or_irq_pin_in,
    output reg powerdown_or_irq_pin_out,
    output reg powerdown_or_irq_pin_oe,
    output reg mac_ref_clock_out,
    output reg reduced_mode,
    output reg crossover_active,
    output reg mdi_crossed,
    output reg [4:0] station_address,
    output reg low_power,
    output reg power_down,
    output reg block_code_bypass,
    output reg serial_network_mode,
    output reg speed_led,
    output reg activity_led
);
    // Worked out wide, then cut to the divider width on purpose
    localparam integer HALF_MII_I =
        `PMC_CLK_MHZ / (2 * `PMC_REF_MII_MHZ);
    localparam integer HALF_RMII_I =
        `PMC_CLK_MHZ / (2 * `PMC_REF_RMII_MHZ);
    localparam [HALF_W-1:0] HALF_MII = HALF_MII_I[HALF_W-1:0];
    localparam [HALF_W-1:0] HALF_RMII = HALF_RMII_I[HALF_W-1:0];

    reg init_q;
    reg rmii_q, mdix_q, sni_q;
    reg [4:0] addr_q;
    reg [15:0] ictl_q, unmask_q, pcs_q, led_q, phyc_q, ten_q, edc_q;
    reg [6:0] flags_q;
    reg pdown_q;
    reg crossed_q;
    reg aw_hold_q, w_hold_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg [15:0] rd_val;
    reg rd_hit;
    wire [4:0] aw_idx = aw_addr_q[6:2];
    wire [4:0] ar_idx = s_axi_araddr[6:2];
    wire do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire is_clear = do_read && (ar_idx == `PMC_IDX_INT_STATUS) &&
        (s_axi_araddr[7] == 1'b0);
    wire irq_pending = ictl_q[`PMC_IC_IRQ_EN] &&
        (|(flags_q & unmask_q[6:0]) || ictl_q[`PMC_IC_TEST]);
    wire ref_clk;

    pmc_clk_div #(
        .HALF_W(HALF_W)
    ) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .half_period(rmii_q ? HALF_RMII : HALF_MII),
        .clk_out(ref_clk)
    );

    // Straps are sampled on the first clock after release
    always @(posedge aclk) begin
        if (!aresetn) begin
            init_q <= 1'b0;
            rmii_q <= 1'b0;
            mdix_q <= 1'b1;
            sni_q <= 1'b0;
            addr_q <= `PMC_ADDR_DEFAULT;
        end else if (!init_q) begin
            init_q <= 1'b1;
            rmii_q <= rx_dv_strap;
            mdix_q <= rx_er_strap;
            sni_q <= serial_network_mode_strap;
            addr_q <= {rxd_strap, col_strap};
        end
    end

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PMC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready;
            s_axi_wready <= !w_hold_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok(aw_addr_q) ?
                    `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end
        end
    end

    function wr_ok;
        input [7:0] a;
        begin
            wr_ok = (a[7] == 1'b0) && (
                a[6:2] == `PMC_IDX_INT_CTRL ||
                a[6:2] == `PMC_IDX_INT_STATUS ||
                a[6:2] == `PMC_IDX_PCS_CFG ||
                a[6:2] == `PMC_IDX_LED_CTRL ||
                a[6:2] == `PMC_IDX_PHY_CTRL ||
                a[6:2] == `PMC_IDX_TEN_BASE ||
                a[6:2] == `PMC_IDX_ENERGY_CTRL ||
                a[6:2] == `PMC_IDX_MODE_CTRL ||
                a[6:2] == `PMC_IDX_PHY_STATUS);
        end
    endfunction

    // Control registers; only the low two byte lanes exist
    wire [15:0] wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire [15:0] wval = w_data_q[15:0];
    wire aw_lo = (aw_addr_q[7] == 1'b0);
    always @(posedge aclk) begin
        if (!aresetn) begin
            ictl_q <= 16'h0000;
            unmask_q <= 16'h0000;
            pcs_q <= 16'h0000;
            led_q <= 16'h0000;
            phyc_q <= 16'h0000;
            ten_q <= 16'h0000;
            edc_q <= 16'h0000;
            pdown_q <= 1'b0;
        end else if (do_write && aw_lo) begin
            case (aw_idx)
                `PMC_IDX_INT_CTRL:
                    ictl_q <= (ictl_q & ~wmask) |
                        (wval & wmask & `PMC_IC_MASK);
                `PMC_IDX_INT_STATUS:
                    unmask_q <= (unmask_q & ~wmask) |
                        (wval & wmask & `PMC_IS_UNMASK_MASK);
                `PMC_IDX_PCS_CFG:
                    pcs_q <= (pcs_q & ~wmask) |
                        (wval & wmask & `PMC_PCS_MASK);
                `PMC_IDX_LED_CTRL:
                    led_q <= (led_q & ~wmask) |
                        (wval & wmask & `PMC_LED_MASK);
                `PMC_IDX_PHY_CTRL:
                    phyc_q <= (phyc_q & ~wmask) |
                        (wval & wmask & `PMC_PHYC_MASK);
                `PMC_IDX_TEN_BASE:
                    ten_q <= (ten_q & ~wmask) |
                        (wval & wmask & `PMC_TEN_MASK);
                `PMC_IDX_ENERGY_CTRL:
                    edc_q <= (edc_q & ~wmask) |
                        (wval & wmask & `PMC_ED_MASK);
                `PMC_IDX_MODE_CTRL:
                    if (w_strb_q[0])
                        pdown_q <= wval[`PMC_MC_PDOWN];
                default: ;
            endcase
        end
    end

    // sticky flags, set wins over read clear
    always @(posedge aclk) begin
        if (!aresetn)
            flags_q <= 7'h00;
        else if (is_clear)
            flags_q <= event_in;
        else
            flags_q <= flags_q | event_in;
    end

    always @* begin
        rd_val = 16'h0000;
        rd_hit = (s_axi_araddr[7] == 1'b0);
        case (ar_idx)
            `PMC_IDX_PHY_STATUS: rd_val[`PMC_PHY_STATUS_IRQ] = irq_pending;
            `PMC_IDX_INT_CTRL: rd_val = ictl_q;
            `PMC_IDX_INT_STATUS: rd_val = {1'b0, flags_q, unmask_q[7:0]};
            `PMC_IDX_PCS_CFG: rd_val = pcs_q;
            `PMC_IDX_LED_CTRL: rd_val = led_q;
            `PMC_IDX_PHY_CTRL: rd_val = phyc_q;
            `PMC_IDX_TEN_BASE: rd_val = ten_q;
            `PMC_IDX_ENERGY_CTRL: rd_val = edc_q;
            `PMC_IDX_MODE_CTRL: begin
                rd_val[`PMC_MC_PDOWN] = pdown_q;
                rd_val[`PMC_MC_PIN_IRQ] = ictl_q[`PMC_IC_OUT_EN];
                rd_val[7:3] = addr_q;
                rd_val[8] = rmii_q;
                rd_val[9] = mdix_q;
                rd_val[10] = sni_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: one read at a time, answered the cycle after take
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PMC_RESP_OKAY;
        end else begin
            // Ready must not wait for arvalid, or an early request hangs
            s_axi_arready <= !s_axi_rvalid;
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {16'h0000, rd_val};
                s_axi_rresp <= rd_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Outputs registered; power and pin logic
    always @(posedge aclk) begin
        if (!aresetn) begin
            powerdown_or_irq_pin_out <= 1'b0;
            powerdown_or_irq_pin_oe <= 1'b0;
            mac_ref_clock_out <= 1'b0;
            reduced_mode <= 1'b0;
            crossover_active <= 1'b1;
            mdi_crossed <= 1'b0;
            crossed_q <= 1'b0;
            station_address <= `PMC_ADDR_DEFAULT;
            low_power <= 1'b0;
            power_down <= 1'b0;
            block_code_bypass <= 1'b0;
            serial_network_mode <= 1'b0;
            speed_led <= 1'b0;
            activity_led <= 1'b0;
        end else begin
            mac_ref_clock_out <= ref_clk;
            reduced_mode <= rmii_q;
            crossover_active <= mdix_q;
            station_address <= addr_q;
            // pair choice latched at negotiation done
            if (!mdix_q)
                crossed_q <= 1'b0;
            else if (negotiation_done)
                crossed_q <= negotiation_crossed;
            mdi_crossed <= crossed_q;
            low_power <= edc_q[`PMC_ED_ENABLE] && !line_activity;
            powerdown_or_irq_pin_out <= 1'b0;
            powerdown_or_irq_pin_oe <= (HAS_IRQ_PIN != 0) &&
                ictl_q[`PMC_IC_OUT_EN] && irq_pending;
            // pin power down or register only
            power_down <= pdown_q || ((HAS_IRQ_PIN != 0) &&
                !ictl_q[`PMC_IC_OUT_EN] && !powerdown_or_irq_pin_in);
            block_code_bypass <= pcs_q[`PMC_PCS_BYPASS];
            // serial mode from strap or register
            serial_network_mode <= sni_q || ten_q[`PMC_TEN_SERIAL];
            speed_led <= led_q[`PMC_LED_SPD_DRV] ?
                led_q[`PMC_LED_SPD_VAL] : speed_led_status;
            activity_led <= led_q[`PMC_LED_ACT_DRV] ?
                led_q[`PMC_LED_ACT_VAL] : activity_led_status;
        end
    end
endmodule

// *** testbench/pmc_top_props.sv ***
`timescale 1ns/1ps
module pmc_top_props (
    input wire aclk,
    input wire aresetn,
    input wire rx_dv_strap,
    input wire rx_er_strap,
    input wire [3:0] rxd_strap,
    input wire col_strap,
    input wire line_activity,
    input wire powerdown_or_irq_pin_out,
    input wire powerdown_or_irq_pin_oe,
    input wire mac_ref_clock_out,
    input wire reduced_mode,
    input wire crossover_active,
    input wire [4:0] station_address,
    input wire low_power,
    input wire power_down
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    strap_mode_a: assert property (
        $rose(aresetn) |-> ##3 reduced_mode == $past(rx_dv_strap, 3))
        else $error("mode strap wrong");
    strap_xover_a: assert property (
        $rose(aresetn) |-> ##3 crossover_active == $past(rx_er_strap, 3))
        else $error("crossover strap wrong");
    strap_addr_a: assert property (
        $rose(aresetn) |-> ##3 station_address[0] == $past(col_strap, 3)
        && station_address[4:1] == $past(rxd_strap, 3))
        else $error("address strap wrong");
    strap_hold_a: assert property (
        aresetn[*5] |-> $stable(reduced_mode) && $stable(crossover_active)
        && $stable(station_address))
        else $error("strap output moved");
    // A gated reference in power saving states is not judged
    ref_mii_a: assert property (
        disable iff (!aresetn || power_down || low_power)
        aresetn[*8] ##0 ($rose(mac_ref_clock_out) && !reduced_mode)
        |-> mac_ref_clock_out[*4] ##1 (!mac_ref_clock_out)[*4])
        else $error("reference not 25 MHz");
    ref_rmii_a: assert property (
        disable iff (!aresetn || power_down || low_power)
        aresetn[*8] ##0 ($rose(mac_ref_clock_out) && reduced_mode)
        |-> mac_ref_clock_out[*2] ##1 (!mac_ref_clock_out)[*2])
        else $error("reference not 50 MHz");
    pin_drain_a: assert property (
        powerdown_or_irq_pin_oe |-> !powerdown_or_irq_pin_out)
        else $error("pin driven high");
    wake_up_a: assert property (
        line_activity[*3] |-> !low_power)
        else $error("low power with line active");
    cover property (reduced_mode);
    cover property ($rose(powerdown_or_irq_pin_oe));
    cover property ($rose(low_power));
endmodule

// *** testbench/pmc_far_model.sv ***
`timescale 1ns/1ps
module pmc_far_model (
    input wire pin_oe,
    input wire pin_out,
    input wire drive_low,
    input wire ref_clk,
    output wire pin_level,
    output integer ref_edges
);
    // Pull-up wins unless a party pulls low
    assign pin_level = (pin_oe && !pin_out) || drive_low ? 1'h0 : 1'h1;
    initial ref_edges = 0;
    // Reference edges as the MAC consumes them
    always @(posedge ref_clk) ref_edges <= ref_edges + 1;
endmodule

// *** testbench/pmc_top_test.sv ***
`timescale 1ns/1ps
module pmc_top_test;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic rx_dv_strap = 1'h0, rx_er_strap = 1'h1, col_strap = 1'h1;
    logic [3:0] rxd_strap = 4'h0;
    logic serial_network_mode_strap = 1'h0, line_activity = 1'h1;
    logic [6:0] event_in = 7'h0;
    logic negotiation_crossed = 1'h1, negotiation_done = 1'h0;
    logic speed_led_status = 1'h0, activity_led_status = 1'h0;
    logic pd_req = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, powerdown_or_irq_pin_in, powerdown_or_irq_pin_out;
    wire powerdown_or_irq_pin_oe, mac_ref_clock_out, reduced_mode;
    wire crossover_active, mdi_crossed, low_power, power_down;
    wire block_code_bypass, serial_network_mode, speed_led, activity_led;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [4:0] station_address;
    integer ref_edges, n, miscompares = 0, checked = 0;
    logic [31:0] rv, d;
    logic [1:0] rs;
    logic [6:0] s;
    logic [7:0] ra [6] = '{8'h44, 8'h58, 8'h60, 8'h64, 8'h68, 8'h74};
    logic [15:0] rm [6] = '{16'h7, 16'h1000, 16'h2d, 16'h40, 16'hf000,
        16'h8000};

    always #2.5 aclk = ~aclk;

    pmc_top dut_u (.*);
    pmc_far_model far_u (
        .pin_oe(powerdown_or_irq_pin_oe),
        .pin_out(powerdown_or_irq_pin_out),
        .drive_low(pd_req),
        .ref_clk(mac_ref_clock_out),
        .pin_level(powerdown_or_irq_pin_in),
        .ref_edges(ref_edges)
    );

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask

    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Address and data are released separately, each when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        rs = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        repeat (50) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'h0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a);
        rs = 2'h3;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        repeat (50) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                rv = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'h0;
                break;
            end
        end
    endtask

    // Straps flip after capture so a late resample shows up
    task automatic do_reset(input logic [6:0] st);
        aresetn <= 1'h0;
        cyc(5);
        {rx_dv_strap, rx_er_strap, rxd_strap, col_strap} <= st;
        aresetn <= 1'h1;
        cyc(4);
        {rx_dv_strap, rx_er_strap, rxd_strap, col_strap} <= ~st;
    endtask

    task automatic pulse(input int i);
        event_in[i] <= 1'h1;
        cyc(1);
        event_in[i] <= 1'h0;
        cyc(3);
    endtask

    initial begin
        #100000;
        miscompares++;
        give_verdict;
    end

    initial begin
        void'($urandom(49246));
        for (int i = 0; i < 3; i++) begin
            s = (i == 0) ? 7'h21 : 7'($urandom);
            do_reset(s);
            negotiation_crossed <= s[3];
            negotiation_done <= 1'h1;
            cyc(1);
            negotiation_done <= 1'h0;
            cyc(3);
            chk("mode", reduced_mode, s[6]);
            chk("xover", crossover_active, s[5]);
            chk("addr", station_address, s[4:0]);
            chk("crossed", mdi_crossed, s[5] & s[3]);
            rd(8'h78);
            chk("straps", rv[9:3], {s[5], s[6], s[4:0]});
            n = ref_edges;
            cyc(80);
            chk("ref", ref_edges - n, s[6] ? 32'h14 : 32'ha);
        end
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            wr(ra[i], d);
            chk("bresp", rs, 2'h0);
            rd(ra[i]);
            chk("rdata", rv, d & rm[i]);
            if (i == 1) chk("bypass", block_code_bypass, d[12]);
            if (i == 4) chk("serial", serial_network_mode, d[15]);
        end
        for (int i = 0; i < 3; i++) begin
            wr(8'h7c + 8'(8 * i), 32'hffff);
            chk("bresp", rs, 2'h2);
            rd(8'h7c + 8'(8 * i));
            chk("rresp", rs, 2'h2);
        end
        for (int i = 0; i < 4; i++) begin
            {speed_led_status, activity_led_status} <= ~2'(i);
            wr(8'h60, {26'h0, 3'h5, i[1], 1'h0, i[0]});
            cyc(3);
            chk("spd_led", speed_led, i[1]);
            chk("act_led", activity_led, i[0]);
        end
        wr(8'h74, 32'h8000);
        line_activity <= 1'h0;
        cyc(8);
        chk("low_power", low_power, 1'h1);
        line_activity <= 1'h1;
        cyc(4);
        chk("wake", low_power, 1'h0);
        wr(8'h44, 32'h3);
        for (int i = 0; i < 7; i++) begin
            wr(8'h48, 32'h1 << i);
            pulse(i);
            chk("irq_pin", powerdown_or_irq_pin_in, 1'h0);
            rd(8'h48);
            chk("status", rv, 32'h101 << i);
            cyc(3);
            chk("irq_clear", powerdown_or_irq_pin_oe, 1'h0);
            wr(8'h48, 32'h7f ^ (32'h1 << i));
            pulse(i);
            chk("masked", powerdown_or_irq_pin_oe, 1'h0);
            rd(8'h48);
        end
        wr(8'h44, 32'h7);
        cyc(3);
        chk("test_irq", powerdown_or_irq_pin_oe, 1'h1);
        wr(8'h44, 32'h6);
        pd_req <= 1'h1;
        cyc(3);
        chk("pin_role", powerdown_or_irq_pin_oe, 1'h0);
        chk("pin_down", power_down, 1'h1);
        pd_req <= 1'h0;
        cyc(3);
        chk("pin_up", power_down, 1'h0);
        wr(8'h78, 32'h1);
        cyc(3);
        chk("reg_down", power_down, 1'h1);
        wr(8'h78, 32'h0);
        cyc(3);
        chk("reg_up", power_down, 1'h0);
        give_verdict;
    end
endmodule

bind pmc_top pmc_top_props chk_u (.*);
